// *** hw/cil_defs.svh ***
// Opcode and field constants for the input, increment and load execution slice
`ifndef CIL_DEFS_SVH
`define CIL_DEFS_SVH
`define CIL_OP_IN_P3 10'h263
`define CIL_OP_INC_Y 10'h013
`define CIL_OP_LDI_MASK 10'h3F0
`define CIL_OP_LDI_BASE 10'h070
`define CIL_LDI_IMM_LSB 0
`define CIL_ACC_RST 4'h0
`define CIL_Y_RST 4'h0
`define CIL_CARRY_RST 1'b0
`define CIL_HI_ZERO 2'h0
`define CIL_Y_STEP 4'h1
`endif

// *** hw/cil_pkg.sv ***
// Types shared by the execution slice
package cil_pkg;
    typedef logic [3:0] cil_nib_t;
    typedef logic [9:0] cil_word_t;
    typedef enum logic [1:0]
    {
        CIL_ST_RUN = 2'b01,
        CIL_ST_LDI_RUN = 2'b10
    } cil_state_e;
endpackage : cil_pkg

// *** hw/cil_pin_sync.sv ***
// Three-stage synchroniser with agreement check for one pin
`timescale 1ns/1ns
module cil_pin_sync
    import cil_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Pin in, filtered level out
    input wire logic pin,
    output logic level
);
    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic level_nxt;

    // Level changes only once the last two stages agree
    assign level_nxt = (s2_r == s3_r) ? s3_r : level;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
            level <= 1'b0;
        end
        else
        begin
            s1_r <= pin;
            s2_r <= s1_r;
            s3_r <= s2_r;
            level <= level_nxt;
        end
    end
endmodule : cil_pin_sync

// *** hw/cil_exec.sv ***
// Execution slice: port three input, Y increment, immediate accumulator load
// What this block does
// - Port-three input copies pin bits one and zero into accumulator bits one, zero.
// - Port-three input clears accumulator bits three and two.
// - Y increment adds one to Y modulo sixteen, carry untouched.
// - Y increment skips the following instruction when new Y is zero.
// - Immediate load writes the four-bit operand into the accumulator, carry untouched.
// - In a run of consecutive immediate loads only the first takes effect.
`timescale 1ns/1ns
`include "cil_defs.svh"
module cil_exec
    import cil_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Instruction stream from fetch
    input wire logic instr_valid,
    input wire logic [9:0] instr_word,
    input wire logic skip_active,
    // Port three pins
    input wire logic port_three_bit_one,
    input wire logic port_three_bit_zero,
    // State shared with the rest of the core
    input wire logic acc_load_en,
    input wire logic [3:0] acc_load_val,
    input wire logic y_load_en,
    input wire logic [3:0] y_load_val,
    input wire logic carry_load_en,
    input wire logic carry_load_val,
    // State out
    output logic [3:0] acc_r,
    output logic [3:0] y_r,
    output logic carry_flag,
    output logic skip_next_r
);
    // Filtered pin levels
    logic p31_lvl;
    logic p30_lvl;
    // Load-run tracker
    cil_state_e state_r;
    cil_state_e state_nxt;
    // Next values of the core state
    logic [3:0] acc_nxt;
    logic [3:0] y_nxt;
    logic skip_next_nxt;
    logic carry_nxt;

    // Pins are asynchronous, so each one gets its own filter
    cil_pin_sync u_sync_b1
    (
        .clk(clk),
        .rst(rst),
        .pin(port_three_bit_one),
        .level(p31_lvl)
    );

    cil_pin_sync u_sync_b0
    (
        .clk(clk),
        .rst(rst),
        .pin(port_three_bit_zero),
        .level(p30_lvl)
    );

    // Decode; a skipped word executes nothing
    wire live = instr_valid && !skip_active;
    wire [9:0] ldi_field = instr_word & `CIL_OP_LDI_MASK;

    // Opcode matches
    wire op_in_p3 = (instr_word == `CIL_OP_IN_P3);
    wire op_inc_y = (instr_word == `CIL_OP_INC_Y);
    wire op_ldi = (ldi_field == `CIL_OP_LDI_BASE);

    // Matches that really execute
    wire is_in_p3 = live && op_in_p3;
    wire is_inc_y = live && op_inc_y;
    wire in_ldi_run = (state_r == CIL_ST_LDI_RUN);

    // Run opens on an executed load and closes on any valid other word
    wire run_start = live && op_ldi;
    wire run_end = instr_valid && !op_ldi;
    wire is_ldi = run_start && !in_ldi_run;

    wire [3:0] ldi_imm = instr_word[`CIL_LDI_IMM_LSB +: 4];
    wire [3:0] y_inc = y_r + `CIL_Y_STEP;
    wire y_wrap = (y_inc == 4'h0);

    // run tracker; a skipped load still continues the run
    always_comb
    begin
        state_nxt = CIL_ST_RUN;
        case (state_r)
            CIL_ST_RUN:
            begin
                if (run_start)
                begin
                    state_nxt = CIL_ST_LDI_RUN;
                end
                else
                begin
                    state_nxt = CIL_ST_RUN;
                end
            end
            CIL_ST_LDI_RUN:
            begin
                if (run_end)
                begin
                    state_nxt = CIL_ST_RUN;
                end
                else
                begin
                    state_nxt = CIL_ST_LDI_RUN;
                end
            end
            default:
            begin
                state_nxt = CIL_ST_RUN;
            end
        endcase
    end

    always_comb
    begin
        acc_nxt = acc_r;
        if (is_in_p3)
        begin
            // low bits from pins, high cleared
            acc_nxt = {`CIL_HI_ZERO, p31_lvl, p30_lvl};
        end
        else if (is_ldi)
        begin
            acc_nxt = ldi_imm;
        end
        else if (acc_load_en)
        begin
            acc_nxt = acc_load_val;
        end
    end

    // Y source selects; the increment outranks other writers
    wire y_take_inc = is_inc_y;
    wire y_take_ext = y_load_en && !is_inc_y;
    assign y_nxt = y_take_inc ? y_inc : (y_take_ext ? y_load_val : y_r);

    assign skip_next_nxt = is_inc_y && y_wrap;

    // carry only changes on external load
    assign carry_nxt = carry_load_en ? carry_load_val : carry_flag;

    // Each register has its own short block
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_r <= CIL_ST_RUN;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            acc_r <= `CIL_ACC_RST;
        end
        else
        begin
            acc_r <= acc_nxt;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            y_r <= `CIL_Y_RST;
        end
        else
        begin
            y_r <= y_nxt;
        end
    end

    // Carry kept unless another instruction writes it
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            carry_flag <= `CIL_CARRY_RST;
        end
        else
        begin
            carry_flag <= carry_nxt;
        end
    end

    // one-cycle pulse; fetch drops the next word
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            skip_next_r <= 1'b0;
        end
        else
        begin
            skip_next_r <= skip_next_nxt;
        end
    end
endmodule : cil_exec

// *** verif/cil_exec_assertions.sv ***
// Checker for the execution slice
`timescale 1ns/1ns
module cil_exec_assertions
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Instruction stream and other writers
    input wire logic instr_valid,
    input wire logic skip_active,
    input wire logic carry_load_en,
    input wire logic acc_load_en,
    input wire logic [9:0] instr_word,
    // State out of the slice
    input wire logic [3:0] acc_r,
    input wire logic [3:0] y_r,
    input wire logic carry_flag,
    input wire logic skip_next_r
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);
    wire ex = instr_valid && !skip_active;
    wire inc = ex && instr_word == 10'h013;
    wire ldi = ex && instr_word[9:4] == 6'h07;
    wire ldw = instr_word[9:4] == 6'h07;
    wire [3:0] imm = instr_word[3:0];
    logic run_r;
    // A skipped load extends a run but never opens one
    always_ff @(posedge clk)
    begin
        if (rst)
            run_r <= 1'b0;
        else if (instr_valid)
            run_r <= ldw && (run_r || !skip_active);
    end
    sequence s_inc;
        inc;
    endsequence
    a_hi_zero: assert property (ex && instr_word == 10'h263 |=> acc_r[3:2] == 2'h0)
        else $error("acc high bits set");
    a_y_step: assert property (s_inc |=> y_r == $past(y_r) + 4'h1)
        else $error("y step");
    a_skip_zero: assert property (s_inc |=> skip_next_r == (y_r == 4'h0))
        else $error("skip vs y");
    a_skip_cause: assert property (!inc |=> !skip_next_r)
        else $error("stray skip");
    a_ldi_value: assert property (ldi && !run_r |=> acc_r == $past(imm))
        else $error("load value");
    a_run_hold: assert property (ldi && run_r && !acc_load_en |=> $stable(acc_r))
        else $error("run load taken");
    a_carry_kept: assert property (ex && !carry_load_en |=> $stable(carry_flag))
        else $error("carry moved");
    a_skip_pulse: assert property (skip_next_r |=> !skip_next_r)
        else $error("skip too long");
endmodule : cil_exec_assertions
bind cil_exec cil_exec_assertions u_chk (.clk(clk), .rst(rst), .instr_valid(instr_valid),
    .skip_active(skip_active), .carry_load_en(carry_load_en), .acc_load_en(acc_load_en),
    .instr_word(instr_word), .acc_r(acc_r), .y_r(y_r), .carry_flag(carry_flag),
    .skip_next_r(skip_next_r));

// *** verif/cil_exec_tb_top.sv ***
// Bench for the execution slice
`timescale 1ns/1ns
module cil_exec_tb_top;
    logic clk = 0, rst = 1, iv = 0, sk = 0, p1 = 0, p0 = 0, ae = 0, ye = 0, ce = 0, cv = 0;
    logic [9:0] w = 10'h000;
    logic [3:0] av = 4'hF, yv = 4'hE, acc, y;
    logic cy, skn;
    int bad_count = 0, checks = 0;
    always #20 clk = ~clk;
    cil_exec u_cil_exec (.clk(clk), .rst(rst), .instr_valid(iv), .instr_word(w),
        .skip_active(sk), .port_three_bit_one(p1), .port_three_bit_zero(p0),
        .acc_load_en(ae), .acc_load_val(av), .y_load_en(ye), .y_load_val(yv),
        .carry_load_en(ce), .carry_load_val(cv), .acc_r(acc), .y_r(y), .carry_flag(cy),
        .skip_next_r(skn));
    task automatic cmp(input logic [3:0] got, input logic [3:0] exp);
        checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask : cmp
    task automatic op(input logic v, input logic [9:0] wd, input logic s);
        iv = v;
        w = wd;
        sk = s;
        @(posedge clk);
        #1;
    endtask : op
    task automatic report_and_stop();
        $display("checks %0d errors %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : report_and_stop
    task automatic t_port(input logic b1, input logic b0);
        ae = 1;
        p1 = b1;
        p0 = b0;
        op(1, 10'h000, 0);
        ae = 0;
        // Pins need a few edges through the filter
        repeat (6) op(0, 10'h000, 0);
        op(1, 10'h263, 0);
        cmp(acc, {2'h0, b1, b0});
    endtask : t_port
    task automatic t_inc();
        ye = 1;
        ce = 1;
        cv = 1;
        op(1, 10'h000, 0);
        ye = 0;
        ce = 0;
        op(1, 10'h013, 0);
        cmp(y, 4'hF);
        cmp({3'h0, skn}, 4'h0);
        op(1, 10'h013, 0);
        cmp(y, 4'h0);
        cmp({3'h0, skn}, 4'h1);
        op(1, 10'h071, 1);
        cmp({cy, acc[2:0]}, 4'h9);
        cmp({3'h0, skn}, 4'h0);
    endtask : t_inc
    task automatic t_load();
        for (int n = 0; n < 16; n++)
        begin
            op(1, 10'h000, 0);
            op(1, {6'h07, 4'(n)}, 0);
            cmp(acc, 4'(n));
            op(1, {6'h07, ~4'(n)}, 0);
            op(0, 10'h000, 0);
            op(1, {6'h07, ~4'(n)}, 1);
            op(1, {6'h07, ~4'(n)}, 0);
            cmp(acc, 4'(n));
        end
        cmp({3'h0, cy}, 4'h1);
    endtask : t_load
    initial
    begin
        repeat (8) @(posedge clk);
        #1;
        rst = 0;
        cmp(y, 4'h0);
        cmp({3'h0, skn}, 4'h0);
        cmp(acc, 4'h0);
        cmp({3'h0, cy}, 4'h0);
        t_port(1, 0);
        t_port(0, 1);
        t_inc();
        t_load();
        report_and_stop();
    end
endmodule : cil_exec_tb_top
